// ---- cpu_pkg.sv ----
/*
  types shared by the sequencer and the operand address unit.
  assumes: nothing beyond the constants header.
*/
package cpu_pkg;

  typedef enum logic [2:0] {
    S_FETCH     = 3'b000,
    S_PFX       = 3'b001,
    S_OPND      = 3'b010,
    S_READ      = 3'b011,
    S_TRAP_IDLE = 3'b100,
    S_PUSH      = 3'b101,
    S_VEC_HI    = 3'b110,
    S_VEC_LO    = 3'b111
  } state_e;

  typedef enum logic [3:0] {
    M_DIRECT          = 4'h0,
    M_INDEX           = 4'h1,
    M_INDEX_POSTINC   = 4'h2,
    M_INDEX_BYTE_OFS  = 4'h3,
    M_INDEX_WORD_OFS  = 4'h4,
    M_STACK_BYTE_OFS  = 4'h5,
    M_STACK_WORD_OFS  = 4'h6,
    M_ABSOLUTE_WORD   = 4'h7,
    M_DIRECT_TO_INDEX = 4'h8,
    M_IMMEDIATE_TO_DIRECT = 4'h9,
    M_BIT_BRANCH      = 4'hA
  } agu_mode_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [7:0]  acc;
    logic [7:0]  flags;
  } cpu_regs_s;

  typedef struct packed {
    logic        valid;
    agu_mode_e   mode;
    logic        taken;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
  } agu_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] src_addr;
    logic [15:0] hx_next;
    logic [15:0] target;
  } agu_rsp_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_bus_s;

endpackage

// ---- cpu_regs.svh ----
/*
  offsets, field positions, reset values and timing counts for the trap,
  test and operand address logic.
  assumes: included by its bare name from the design and bench files.
*/
`ifndef CPU_REGS_SVH
`define CPU_REGS_SVH

// opcodes handled by the sequencer
`define OP_TRAP        8'h83
`define OP_TEST_DIR    8'h3D
`define OP_TEST_ACC    8'h4D
`define OP_TEST_XLO    8'h5D
`define OP_TEST_XOFS   8'h6D
`define OP_TEST_INDEX  8'h7D
`define OP_PREFIX      8'h9E
`define OP_TEST_SOFS   8'h6D

// condition flags register bit positions
`define FLAG_V         7
`define FLAG_H         4
`define FLAG_I         3
`define FLAG_N         2
`define FLAG_Z         1
`define FLAG_C         0

// reset values
`define RST_FLAGS      8'h68
`define RST_SP         16'h00FF
`define RST_PC         16'h0000
`define RST_HX         16'h0000
`define RST_ACC        8'h00

// vector locations
`define TRAP_VEC_HI    16'hFFFC
`define TRAP_VEC_LO    16'hFFFD
`define IRQ_VEC_HI     16'hFFFA
`define IRQ_VEC_LO     16'hFFFB

// timing, and the direct page high byte
`define TRAP_CYCLES    9
`define PUSH_LAST      3'h4
`define DIRECT_PAGE    8'h00

`endif

// ---- cpu_trap_test_and_address_modes.sv ----
/*
  sequencer for the software trap and the test instructions, plus a
  registered operand address port covering every addressing mode.
  assumes: memory read data is valid in the cycle its address is shown;
  opcodes outside this subset retire in one cycle, or in two after the 9E prefix, and are flagged.
*/
`timescale 1ns/10ps
`include "cpu_regs.svh"

// Contract
// - trap opcode 83 takes 9 cycles, pushes pc low, pc high, x, a, flags.
// - after stacking, set interrupt mask, load pc from trap vector high then low.
// - test opcodes 3D, 4D, 5D, 6D, 7D, 9E6D take 3, 1, 1, 3, 2, 4 cycles.
// - test clears overflow, sets negative and zero from operand, keeps others.
// - stack byte offset mode address is stack pointer plus offset byte.
// - stack word offset mode address is stack pointer plus two-byte offset.
// - index byte offset mode address is index pair plus offset byte.
// - index word offset mode adds high-then-low offset to index pair.
// - index post-increment mode uses index pair, then increments it.
// - direct-to-index: direct source, index target, then increment; immediate-to-direct.
// - absolute word mode address comes from two bytes, high first.
// - bit branch reads direct address, then signed offset added when taken.
module cpu_trap_test_and_address_modes (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  // memory
  input  wire logic [7:0]        i_mem_rdata,
  output cpu_pkg::mem_bus_s      o_mem,
  // interrupt request
  input  wire logic              i_irq_req,
  // address port
  input  wire cpu_pkg::agu_req_s i_agu_req,
  output cpu_pkg::agu_rsp_s      o_agu_rsp,
  // status
  output cpu_pkg::cpu_regs_s     o_regs,
  output logic                   o_insn_done,
  output logic                   o_unknown_op
);
  import cpu_pkg::*;

  state_e     state_q, state_d;
  agu_mode_e  mode_q, mode_d;
  cpu_regs_s  regs_q, regs_d;
  mem_bus_s   mem_q, mem_d;
  agu_rsp_s   agu_q, agu_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] vec_hi_q, vec_hi_d;
  logic       vec_irq_q, vec_irq_d;
  logic       done_q, done_d;
  logic       unk_q, unk_d;
  logic       next_insn;
  logic [15:0] core_addr;
  logic [15:0] port_addr;
  logic [15:0] port_src;
  logic [15:0] port_hx_next;
  logic [15:0] port_target;

  // flags after a test of one byte
  function automatic logic [7:0] test_flags(input logic [7:0] flg, input logic [7:0] val);
    logic [7:0] f;
    f = flg;
    f[`FLAG_V] = 1'b0;
    f[`FLAG_N] = val[7];
    f[`FLAG_Z] = (val == 8'h00);
    return f;
  endfunction

  // byte stacked at each push step
  function automatic logic [7:0] push_byte(input logic [2:0] k, input cpu_regs_s r);
    logic [7:0] b;
    case (k)
      3'h0:    b = r.pc[7:0];
      3'h1:    b = r.pc[15:8];
      3'h2:    b = r.hx[7:0];
      3'h3:    b = r.acc;
      default: b = r.flags;
    endcase
    return b;
  endfunction

  // operand address for the sequencer
  operand_address_unit u_core_agu (
    .i_mode     (mode_q),
    .i_taken    (1'b0),
    .i_byte1    (i_mem_rdata),
    .i_byte2    (8'h00),
    .i_hx       (regs_q.hx),
    .i_sp       (regs_q.sp),
    .i_pc       (regs_q.pc),
    .o_addr     (core_addr),
    .o_src_addr (),
    .o_hx_next  (),
    .o_target   ()
  );

  // operand address for the request port
  operand_address_unit u_port_agu (
    .i_mode     (i_agu_req.mode),
    .i_taken    (i_agu_req.taken),
    .i_byte1    (i_agu_req.byte1),
    .i_byte2    (i_agu_req.byte2),
    .i_hx       (regs_q.hx),
    .i_sp       (regs_q.sp),
    .i_pc       (regs_q.pc),
    .o_addr     (port_addr),
    .o_src_addr (port_src),
    .o_hx_next  (port_hx_next),
    .o_target   (port_target)
  );

  // sequencer next state
  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    regs_d    = regs_q;
    cnt_d     = cnt_q;
    vec_hi_d  = vec_hi_q;
    vec_irq_d = vec_irq_q;
    mem_d     = '{rd: 1'b0, wr: 1'b0, addr: mem_q.addr, wdata: 8'h00};
    done_d    = 1'b0;
    unk_d     = 1'b0;
    next_insn = 1'b0;
    case (state_q)
      S_FETCH: begin
        regs_d.pc = regs_q.pc + 16'h0001;
        case (i_mem_rdata)
          `OP_TRAP: begin
            state_d   = S_TRAP_IDLE;
            vec_irq_d = 1'b0;
          end
          `OP_TEST_ACC: begin
            regs_d.flags = test_flags(regs_q.flags, regs_q.acc);
            done_d       = 1'b1;
            next_insn    = 1'b1;
          end
          `OP_TEST_XLO: begin
            regs_d.flags = test_flags(regs_q.flags, regs_q.hx[7:0]);
            done_d       = 1'b1;
            next_insn    = 1'b1;
          end
          `OP_TEST_DIR, `OP_TEST_XOFS: begin
            mode_d     = (i_mem_rdata == `OP_TEST_DIR) ? M_DIRECT : M_INDEX_BYTE_OFS;
            state_d    = S_OPND;
            mem_d.addr = regs_q.pc + 16'h0001;
            mem_d.rd   = 1'b1;
          end
          `OP_TEST_INDEX: begin
            state_d    = S_READ;
            mem_d.addr = regs_q.hx;
            mem_d.rd   = 1'b1;
          end
          `OP_PREFIX: begin
            state_d    = S_PFX;
            mem_d.addr = regs_q.pc + 16'h0001;
            mem_d.rd   = 1'b1;
          end
          default: begin
            unk_d     = 1'b1;
            next_insn = 1'b1;
          end
        endcase
      end
      S_PFX: begin
        regs_d.pc = regs_q.pc + 16'h0001;
        if (i_mem_rdata == `OP_TEST_SOFS) begin
          mode_d     = M_STACK_BYTE_OFS;
          state_d    = S_OPND;
          mem_d.addr = regs_q.pc + 16'h0001;
          mem_d.rd   = 1'b1;
        end else begin
          unk_d     = 1'b1;
          next_insn = 1'b1;
        end
      end
      S_OPND: begin
        regs_d.pc  = regs_q.pc + 16'h0001;
        state_d    = S_READ;
        mem_d.addr = core_addr;
        mem_d.rd   = 1'b1;
      end
      S_READ: begin
        regs_d.flags = test_flags(regs_q.flags, i_mem_rdata);
        done_d     = 1'b1;
        next_insn  = 1'b1;
      end
      S_TRAP_IDLE: begin
        state_d     = S_PUSH;
        cnt_d       = 3'h0;
        mem_d.addr  = regs_q.sp;
        mem_d.wr    = 1'b1;
        mem_d.wdata = push_byte(3'h0, regs_q);
      end
      S_PUSH: begin
        regs_d.sp = regs_q.sp - 16'h0001;
        if (cnt_q != `PUSH_LAST) begin
          cnt_d       = cnt_q + 3'h1;
          mem_d.addr  = regs_q.sp - 16'h0001;
          mem_d.wr    = 1'b1;
          mem_d.wdata = push_byte(cnt_q + 3'h1, regs_q);
        end else begin
          regs_d.flags[`FLAG_I] = 1'b1;
          state_d    = S_VEC_HI;
          mem_d.addr = vec_irq_q ? `IRQ_VEC_HI : `TRAP_VEC_HI;
          mem_d.rd   = 1'b1;
        end
      end
      S_VEC_HI: begin
        vec_hi_d   = i_mem_rdata;
        state_d    = S_VEC_LO;
        mem_d.addr = vec_irq_q ? `IRQ_VEC_LO : `TRAP_VEC_LO;
        mem_d.rd   = 1'b1;
      end
      S_VEC_LO: begin
        regs_d.pc = {vec_hi_q, i_mem_rdata};
        done_d    = 1'b1;
        next_insn = 1'b1;
      end
      default: begin
        state_d   = S_FETCH;
        next_insn = 1'b1;
      end
    endcase
    // interrupt requests are only looked at between instructions
    if (next_insn) begin
      if (i_irq_req && !regs_d.flags[`FLAG_I]) begin
        state_d   = S_TRAP_IDLE;
        vec_irq_d = 1'b1;
      end else begin
        state_d    = S_FETCH;
        mem_d.addr = regs_d.pc;
        mem_d.rd   = 1'b1;
      end
    end
    // address port, with the index update of the post-increment modes
    agu_d = '{valid: i_agu_req.valid, addr: port_addr, src_addr: port_src,
              hx_next: port_hx_next, target: port_target};
    if (i_agu_req.valid && port_hx_next != regs_q.hx) begin
      regs_d.hx = port_hx_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q   <= S_FETCH;
      mode_q    <= M_DIRECT;
      regs_q    <= '{pc: `RST_PC, sp: `RST_SP, hx: `RST_HX, acc: `RST_ACC, flags: `RST_FLAGS};
      mem_q     <= '{rd: 1'b1, wr: 1'b0, addr: `RST_PC, wdata: 8'h00};
      agu_q     <= '0;
      cnt_q     <= 3'h0;
      vec_hi_q  <= 8'h00;
      vec_irq_q <= 1'b0;
      done_q    <= 1'b0;
      unk_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      regs_q    <= regs_d;
      mem_q     <= mem_d;
      agu_q     <= agu_d;
      cnt_q     <= cnt_d;
      vec_hi_q  <= vec_hi_d;
      vec_irq_q <= vec_irq_d;
      done_q    <= done_d;
      unk_q     <= unk_d;
    end
  end

  assign o_mem        = mem_q;
  assign o_regs       = regs_q;
  assign o_agu_rsp    = agu_q;
  assign o_insn_done  = done_q;
  assign o_unknown_op = unk_q;

  // checks
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence trap_fetch_s;
    state_q == S_FETCH && i_mem_rdata == `OP_TRAP;
  endsequence

  sequence trap_body_s;
    state_q == S_TRAP_IDLE ##1 (state_q == S_PUSH)[*5] ##1 state_q == S_VEC_HI
      ##1 state_q == S_VEC_LO;
  endsequence

  trap_length_a: assert property (trap_fetch_s |-> ##9 o_insn_done)
    else $error("trap did not finish in 9 cycles");

  trap_atomic_a: assert property (trap_fetch_s |=> trap_body_s)
    else $error("trap stacking sequence broken");

  push_first_a: assert property (state_q == S_PUSH && cnt_q == 3'h0 |->
      o_mem.wr && o_mem.addr == regs_q.sp && o_mem.wdata == regs_q.pc[7:0])
    else $error("first push is not pc low byte");

  push_flags_a: assert property (state_q == S_PUSH && cnt_q == `PUSH_LAST |->
      o_mem.wdata == regs_q.flags && o_mem.wr)
    else $error("last push is not the flags");

  sp_decrement_a: assert property (state_q == S_PUSH |=>
      regs_q.sp == $past(regs_q.sp) - 16'h0001)
    else $error("stack pointer not decremented");

  mask_set_a: assert property (state_q == S_PUSH && cnt_q == `PUSH_LAST |=>
      regs_q.flags[`FLAG_I] && regs_q.flags[7:4] == $past(regs_q.flags[7:4])
      && regs_q.flags[2:0] == $past(regs_q.flags[2:0])
      && o_mem.rd && (vec_irq_q || o_mem.addr == `TRAP_VEC_HI))
    else $error("mask not set or flags changed on trap");

  vector_load_a: assert property (state_q == S_VEC_LO && !vec_irq_q |=>
      regs_q.pc == {$past(vec_hi_q), $past(i_mem_rdata)})
    else $error("pc not loaded from vector");

  test_flags_a: assert property (state_q == S_READ |=> !regs_q.flags[`FLAG_V]
      && regs_q.flags[`FLAG_N] == $past(i_mem_rdata[7])
      && regs_q.flags[`FLAG_Z] == ($past(i_mem_rdata) == 8'h00)
      && regs_q.flags[`FLAG_C] == $past(regs_q.flags[`FLAG_C]))
    else $error("test flags wrong");

  test_dir_len_a: assert property (state_q == S_FETCH && i_mem_rdata == `OP_TEST_DIR
      |-> ##3 o_insn_done)
    else $error("direct test length wrong");

  stack_ofs_a: assert property (state_q == S_OPND && mode_q == M_STACK_BYTE_OFS |=>
      o_mem.addr == $past(regs_q.sp) + {8'h00, $past(i_mem_rdata)})
    else $error("stack byte offset address wrong");

  postinc_a: assert property (i_agu_req.valid && i_agu_req.mode == M_INDEX_POSTINC |=>
      o_agu_rsp.addr == $past(regs_q.hx) && regs_q.hx == $past(regs_q.hx) + 16'h0001)
    else $error("post increment wrong");

  absolute_addr_a: assert property (i_agu_req.valid && i_agu_req.mode == M_ABSOLUTE_WORD
      |=> o_agu_rsp.addr == {$past(i_agu_req.byte1), $past(i_agu_req.byte2)})
    else $error("absolute address byte order wrong");

endmodule

// ---- cpu_trap_test_and_address_modes_tb_top.sv ----
/*
  self-checking bench for the trap, test and operand address sequencer.
  assumes: cpu_pkg and cpu_regs.svh compiled first; memory is modelled here.
*/
`timescale 1ns/10ps
`include "cpu_regs.svh"

module cpu_trap_test_and_address_modes_tb_top;
  import cpu_pkg::*;

  logic        i_core_clk;
  logic        i_rst_b;
  logic [7:0]  i_mem_rdata;
  mem_bus_s    o_mem;
  logic        i_irq_req;
  agu_req_s    i_agu_req;
  agu_rsp_s    o_agu_rsp;
  cpu_regs_s   o_regs;
  logic        o_insn_done;
  logic        o_unknown_op;

  int          failures;
  int          num_checks;
  int          cyc;
  logic [7:0]  mem [0:65535];
  int          gaps[$];
  logic [7:0]  flags_at[$];
  logic [15:0] fetch_at[$];
  logic [15:0] sp_at[$];
  logic [15:0] waddr[$];
  logic [7:0]  wdat[$];

  cpu_trap_test_and_address_modes cpu_trap_test_and_address_modes_i (
    .i_core_clk   (i_core_clk),
    .i_rst_b      (i_rst_b),
    .i_mem_rdata  (i_mem_rdata),
    .o_mem        (o_mem),
    .i_irq_req    (i_irq_req),
    .i_agu_req    (i_agu_req),
    .o_agu_rsp    (o_agu_rsp),
    .o_regs       (o_regs),
    .o_insn_done  (o_insn_done),
    .o_unknown_op (o_unknown_op)
  );

  always #25 i_core_clk = ~i_core_clk;

  // memory: log writes, serve read data for the shown address
  always @(negedge i_core_clk) begin
    if (o_mem.wr === 1'b1) begin
      mem[o_mem.addr] = o_mem.wdata;
      waddr.push_back(o_mem.addr);
      wdat.push_back(o_mem.wdata);
    end
    i_mem_rdata <= mem[o_mem.addr];
  end

  // cycles between completions, with state seen at each completion
  always @(negedge i_core_clk) begin
    if (i_rst_b === 1'b1) begin
      cyc++;
      if (o_insn_done === 1'b1) begin
        gaps.push_back(cyc);
        flags_at.push_back(o_regs.flags);
        fetch_at.push_back(o_mem.addr);
        sp_at.push_back(o_regs.sp);
        cyc = 0;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // tests 4D 5D 3D 6D 7D 9E6D, then trap 83 at 000A
  task automatic test_insns_and_trap();
    int         n;
    int         exp_gap [5];
    logic [7:0] exp_flg [5];
    logic [15:0] exp_wa [5];
    logic [7:0] exp_wd [5];
    exp_gap = '{1, 3, 3, 2, 4};
    exp_flg = '{8'h6A, 8'h68, 8'h6A, 8'h68, 8'h6A};
    exp_wa = '{16'h00FF, 16'h00FE, 16'h00FD, 16'h00FC, 16'h00FB};
    exp_wd = '{8'h0B, 8'h00, 8'h00, 8'h00, 8'h6A};
    n = 0;
    while (gaps.size() < 7 && n < 200) begin
      @(negedge i_core_clk);
      n++;
    end
    if (gaps.size() < 7) begin
      failures++;
      end_sim();
    end
    for (int k = 0; k < 5; k++) begin
      check(gaps[k+1], exp_gap[k]);
      check(flags_at[k+1], exp_flg[k]);
    end
    check(gaps[6], `TRAP_CYCLES);
    check(waddr.size(), 5);
    for (int k = 0; k < waddr.size() && k < 5; k++) begin
      check({waddr[k], wdat[k]}, {exp_wa[k], exp_wd[k]});
    end
    check(sp_at[6], 16'h00FA);
    check(fetch_at[6], 16'h1234);
    check(flags_at[6][`FLAG_I], 1'b1);
    check(flags_at[6], 8'h6A);
  endtask

  // one address request, driven at a falling edge, judged one cycle on
  task automatic agu_one(input agu_mode_e m, input logic t);
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [15:0] es;
    logic [15:0] eh;
    logic [15:0] et;
    hx = o_regs.hx;
    sp = o_regs.sp;
    pc = o_regs.pc;
    i_agu_req = '{1'b1, m, t, 8'h12, 8'hF0};
    ea = 16'h0000;
    es = 16'h0000;
    eh = hx;
    et = pc;
    case (m)
      M_DIRECT:              ea = 16'h0012;
      M_INDEX:               ea = hx;
      M_INDEX_POSTINC: begin
        ea = hx;
        eh = hx + 16'h0001;
      end
      M_INDEX_BYTE_OFS:      ea = hx + 16'h0012;
      M_INDEX_WORD_OFS:      ea = hx + 16'h12F0;
      M_STACK_BYTE_OFS:      ea = sp + 16'h0012;
      M_STACK_WORD_OFS:      ea = sp + 16'h12F0;
      M_ABSOLUTE_WORD:       ea = 16'h12F0;
      M_DIRECT_TO_INDEX: begin
        es = 16'h0012;
        ea = hx;
        eh = hx + 16'h0001;
      end
      M_IMMEDIATE_TO_DIRECT: ea = 16'h00F0;
      default: begin
        ea = 16'h0012;
        et = t ? pc + 16'hFFF0 : pc;
      end
    endcase
    @(negedge i_core_clk);
    check(o_agu_rsp.valid, 1'b1);
    check(o_agu_rsp.addr, ea);
    check(o_agu_rsp.src_addr, es);
    if (m == M_INDEX_POSTINC || m == M_DIRECT_TO_INDEX) begin
      check(o_agu_rsp.hx_next, eh);
      check(o_regs.hx, eh);
    end
    if (m == M_BIT_BRANCH) begin
      check(o_agu_rsp.target, et);
    end
  endtask

  task automatic test_agu_modes();
    @(negedge i_core_clk);
    agu_one(M_INDEX, 1'b0);
    agu_one(M_INDEX_POSTINC, 1'b0);
    agu_one(M_INDEX_POSTINC, 1'b0);
    agu_one(M_INDEX_BYTE_OFS, 1'b0);
    agu_one(M_INDEX_WORD_OFS, 1'b0);
    agu_one(M_STACK_BYTE_OFS, 1'b0);
    agu_one(M_STACK_WORD_OFS, 1'b0);
    agu_one(M_ABSOLUTE_WORD, 1'b0);
    agu_one(M_DIRECT_TO_INDEX, 1'b0);
    agu_one(M_IMMEDIATE_TO_DIRECT, 1'b0);
    agu_one(M_DIRECT, 1'b0);
    agu_one(M_BIT_BRANCH, 1'b1);
    agu_one(M_BIT_BRANCH, 1'b0);
    i_agu_req.valid = 1'b0;
    @(negedge i_core_clk);
    check(o_agu_rsp.valid, 1'b0);
    // filler past the vector target retires as unknown
    check(o_unknown_op, 1'b1);
    check(o_insn_done, 1'b0);
  endtask

  // watchdog: 2000 cycles, well past the few dozen cycles the tests need
  initial begin
    #(50 * 2000);
    failures++;
    end_sim();
  end

  initial begin
    logic [7:0] prog [11];
    prog = '{8'h4D, 8'h5D, 8'h3D, 8'h80, 8'h6D, 8'h10, 8'h7D, 8'h9E, 8'h6D, 8'h05, 8'h83};
    i_core_clk = 1'b0;
    i_rst_b = 1'b0;
    i_mem_rdata = 8'h00;
    i_irq_req = 1'b1;
    i_agu_req = '0;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'h9D;
    end
    for (int a = 0; a < 11; a++) begin
      mem[a] = prog[a];
    end
    mem[16'h0080] = 8'h7F;
    mem[16'h0010] = 8'h00;
    mem[16'h0104] = 8'h00;
    mem[16'hFFFC] = 8'h12;
    mem[16'hFFFD] = 8'h34;
    repeat (3) @(negedge i_core_clk);
    i_rst_b <= 1'b1;
    test_insns_and_trap();
    test_agu_modes();
    end_sim();
  end
endmodule

// ---- operand_address_unit.sv ----
/*
  combinational operand address former for every addressing mode.
  assumes: bytes are given in instruction stream order, byte1 first.
*/
`timescale 1ns/10ps
`include "cpu_regs.svh"

module operand_address_unit (
  // request
  input  wire cpu_pkg::agu_mode_e i_mode,
  input  wire logic               i_taken,
  input  wire logic [7:0]         i_byte1,
  input  wire logic [7:0]         i_byte2,
  // core state
  input  wire logic [15:0]        i_hx,
  input  wire logic [15:0]        i_sp,
  input  wire logic [15:0]        i_pc,
  // result
  output logic      [15:0]        o_addr,
  output logic      [15:0]        o_src_addr,
  output logic      [15:0]        o_hx_next,
  output logic      [15:0]        o_target
);
  import cpu_pkg::*;

  always_comb begin
    o_addr     = {`DIRECT_PAGE, i_byte1};
    o_src_addr = 16'h0000;
    o_hx_next  = i_hx;
    o_target   = i_pc;
    case (i_mode)
      M_DIRECT:              o_addr = {`DIRECT_PAGE, i_byte1};
      M_INDEX:               o_addr = i_hx;
      M_INDEX_POSTINC: begin
        o_addr    = i_hx;
        o_hx_next = i_hx + 16'h0001;
      end
      M_INDEX_BYTE_OFS:      o_addr = i_hx + {8'h00, i_byte1};
      M_INDEX_WORD_OFS:      o_addr = i_hx + {i_byte1, i_byte2};
      M_STACK_BYTE_OFS:      o_addr = i_sp + {8'h00, i_byte1};
      M_STACK_WORD_OFS:      o_addr = i_sp + {i_byte1, i_byte2};
      M_ABSOLUTE_WORD:       o_addr = {i_byte1, i_byte2};
      M_DIRECT_TO_INDEX: begin
        o_src_addr = {`DIRECT_PAGE, i_byte1};
        o_addr     = i_hx;
        o_hx_next  = i_hx + 16'h0001;
      end
      M_IMMEDIATE_TO_DIRECT: o_addr = {`DIRECT_PAGE, i_byte2};
      M_BIT_BRANCH: begin
        o_addr = {`DIRECT_PAGE, i_byte1};
        if (i_taken) begin
          o_target = i_pc + {{8{i_byte2[7]}}, i_byte2};
        end
      end
      default:               o_addr = {`DIRECT_PAGE, i_byte1};
    endcase
  end

endmodule
